// *** bjd_branch_jump.sv ***
`timescale 1ns/10ps
`include "bjd_consts.svh"

module bjd_branch_jump #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [15:0] pc_in,
  input wire bjd_pkg::bjd_core_s core,
  input wire logic [7:0] mem_rdata,
  output bjd_pkg::bjd_mem_s mem,
  output logic done,
  output logic busy,
  output logic unsupported,
  output logic [15:0] pc_out,
  output logic [7:0] sp_out,
  output logic [7:0] y_out,
  output logic y_we
);

  // ========================================
  // Types and state
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DP,
    ST_ABS_LO,
    ST_ABS_HI,
    ST_MEM,
    ST_DEC_WR,
    ST_REL,
    ST_PUSH_H,
    ST_PUSH_L,
    ST_PTR_LO,
    ST_PTR_HI,
    ST_WAIT
  } bjd_step_e;

  bjd_step_e st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0] tgt, next_tgt;
  logic [15:0] pcw, next_pcw;
  logic [15:0] ea, next_ea;
  logic [15:0] ret, next_ret;
  logic [15:0] tpc, next_tpc;
  logic [7:0] lo, next_lo;
  logic [7:0] mval, next_mval;
  logic [7:0] sp, next_sp;
  bjd_pkg::bjd_dec_s dq, next_dq;
  bjd_pkg::bjd_core_s cq, next_cq;
  bjd_pkg::bjd_dec_s dec;
  bjd_pkg::bjd_mem_s next_mem;
  logic next_done, next_busy, next_unsup, next_y_we;
  logic [15:0] next_pc_out;
  logic [7:0] next_y_out;
  logic take;
  logic [15:0] rel_base;
  logic [15:0] rel_target;
  logic [7:0] dp_hi;

  bjd_decode u_decode (
    .opcode(opcode),
    .core(core),
    .dec(dec)
  );

  // ========================================
  // Branch condition and target
  // Flag conditions are evaluated on the flags latched at start
  always_comb begin
    case (dq.cls)
      bjd_pkg::BJD_C_FLAG: take = dq.flag_take;
      bjd_pkg::BJD_C_BIT_A: take = (cq.a[dq.bit_num] == dq.bit_pol);
      bjd_pkg::BJD_C_BIT_DP: take = (mval[dq.bit_num] == dq.bit_pol);
      bjd_pkg::BJD_C_CMP_DP,
      bjd_pkg::BJD_C_CMP_DPX: take = (cq.a != mval);
      bjd_pkg::BJD_C_DEC_DP: take = (mval != 8'h01);
      bjd_pkg::BJD_C_DEC_Y: take = (cq.y != 8'h01);
      default: take = 1'b0;
    endcase
    rel_base = pcw + 16'h0001;
    rel_target = rel_base + {{8{mem_rdata[7]}}, mem_rdata};
    dp_hi = {7'h00, cq.g};
  end

  // ========================================
  // Sequencer
  always_comb begin
    logic fin;
    logic [3:0] tv;
    fin = 1'b0;
    tv = dq.cyc_nt;
    next_st = st;
    next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    next_tgt = tgt;
    next_pcw = pcw;
    next_ea = ea;
    next_ret = ret;
    next_tpc = tpc;
    next_lo = lo;
    next_mval = mval;
    next_sp = sp;
    next_dq = dq;
    next_cq = cq;
    next_done = 1'b0;
    next_unsup = unsupported;
    next_pc_out = pc_out;
    next_y_out = y_out;
    next_y_we = 1'b0;
    case (st)
      ST_IDLE: begin
        next_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
        if (start) begin
          next_dq = dec;
          next_cq = core;
          next_pcw = pc_in;
          next_sp = core.sp;
          next_ret = pc_in;
          next_unsup = 1'b0;
          case (dec.cls)
            bjd_pkg::BJD_C_FLAG, bjd_pkg::BJD_C_BIT_A,
            bjd_pkg::BJD_C_DEC_Y: next_st = ST_REL;
            bjd_pkg::BJD_C_JMP_ABS, bjd_pkg::BJD_C_JMP_IABS,
            bjd_pkg::BJD_C_CALL_ABS: next_st = ST_ABS_LO;
            bjd_pkg::BJD_C_TABLE: next_st = ST_PUSH_H;
            bjd_pkg::BJD_C_NONE: begin
              // Foreign opcodes are handed back untouched
              next_done = 1'b1;
              next_unsup = 1'b1;
              next_pc_out = pc_in;
            end
            default: next_st = ST_DP;
          endcase
        end
      end
      ST_DP: begin
        next_pcw = pcw + 16'h0001;
        next_ea = {dp_hi, mem_rdata};
        next_ret = pcw + 16'h0001;
        case (dq.cls)
          bjd_pkg::BJD_C_CMP_DPX: begin
            next_ea = {dp_hi, mem_rdata + cq.x};
            next_st = ST_MEM;
          end
          bjd_pkg::BJD_C_JMP_IDP: next_st = ST_PTR_LO;
          bjd_pkg::BJD_C_CALL_IDP: next_st = ST_PUSH_H;
          bjd_pkg::BJD_C_UPAGE: begin
            next_tpc = {`BJD_UPAGE_HIGH, mem_rdata};
            next_st = ST_PUSH_H;
          end
          default: next_st = ST_MEM;
        endcase
      end
      ST_MEM: begin
        next_mval = mem_rdata;
        next_st = (dq.cls == bjd_pkg::BJD_C_DEC_DP) ? ST_DEC_WR : ST_REL;
      end
      ST_DEC_WR: next_st = ST_REL;
      ST_ABS_LO: begin
        next_lo = mem_rdata;
        next_pcw = pcw + 16'h0001;
        next_st = ST_ABS_HI;
      end
      ST_ABS_HI: begin
        next_pcw = pcw + 16'h0001;
        next_ret = pcw + 16'h0001;
        next_tpc = {mem_rdata, lo};
        next_ea = {mem_rdata, lo};
        case (dq.cls)
          bjd_pkg::BJD_C_JMP_ABS: fin = 1'b1;
          bjd_pkg::BJD_C_JMP_IABS: next_st = ST_PTR_LO;
          default: next_st = ST_PUSH_H;
        endcase
      end
      ST_PUSH_H: begin
        next_sp = sp - 8'h01;
        next_st = ST_PUSH_L;
      end
      ST_PUSH_L: begin
        next_sp = sp - 8'h01;
        case (dq.cls)
          bjd_pkg::BJD_C_CALL_IDP: next_st = ST_PTR_LO;
          bjd_pkg::BJD_C_TABLE: begin
            next_ea = `BJD_VEC_BASE + {11'h000, dq.vec, 1'b0};
            next_st = ST_PTR_LO;
          end
          default: fin = 1'b1;
        endcase
      end
      ST_PTR_LO: begin
        next_lo = mem_rdata;
        next_ea = ea + 16'h0001;
        next_st = ST_PTR_HI;
      end
      ST_PTR_HI: begin
        next_tpc = {mem_rdata, lo};
        fin = 1'b1;
      end
      ST_REL: begin
        next_pcw = rel_base;
        next_tpc = take ? rel_target : rel_base;
        if (take) begin
          tv = dq.cyc_t;
        end
        if (dq.cls == bjd_pkg::BJD_C_DEC_Y) begin
          next_y_out = cq.y - 8'h01;
        end
        fin = 1'b1;
      end
      ST_WAIT: begin
        if (cnt[3:0] == tgt - 4'h1) begin
          next_done = 1'b1;
          next_pc_out = tpc;
          next_y_we = (dq.cls == bjd_pkg::BJD_C_DEC_Y);
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    // Pad to the documented cycle count so timing is opcode exact
    if (fin) begin
      next_tgt = tv;
      if (cnt[3:0] >= tv - 4'h1) begin
        next_done = 1'b1;
        next_pc_out = next_tpc;
        next_y_we = (dq.cls == bjd_pkg::BJD_C_DEC_Y);
        next_st = ST_IDLE;
      end else begin
        next_st = ST_WAIT;
      end
    end
    next_busy = (next_st != ST_IDLE);
  end

  // ========================================
  // Bus request for the coming cycle
  // Built from next values so the port is a plain flop output
  always_comb begin
    next_mem = '0;
    case (next_st)
      ST_DP, ST_ABS_LO, ST_ABS_HI, ST_REL: begin
        next_mem.addr = next_pcw;
        next_mem.rd = 1'b1;
      end
      ST_MEM, ST_PTR_LO, ST_PTR_HI: begin
        next_mem.addr = next_ea;
        next_mem.rd = 1'b1;
      end
      ST_DEC_WR: begin
        next_mem.addr = next_ea;
        next_mem.wr = 1'b1;
        next_mem.wdata = next_mval - 8'h01;
      end
      ST_PUSH_H: begin
        next_mem.addr = {`BJD_STACK_PAGE, next_sp};
        next_mem.wr = 1'b1;
        next_mem.wdata = next_ret[15:8];
      end
      ST_PUSH_L: begin
        next_mem.addr = {`BJD_STACK_PAGE, next_sp};
        next_mem.wr = 1'b1;
        next_mem.wdata = next_ret[7:0];
      end
      default: next_mem = '0;
    endcase
  end

  // ========================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= ST_IDLE;
      cnt <= '0;
      tgt <= '0;
      pcw <= '0;
      ea <= '0;
      ret <= '0;
      tpc <= '0;
      lo <= '0;
      mval <= '0;
      sp <= '0;
      dq <= '0;
      cq <= '0;
      mem <= '0;
      done <= 1'b0;
      busy <= 1'b0;
      unsupported <= 1'b0;
      pc_out <= '0;
      y_out <= '0;
      y_we <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      tgt <= next_tgt;
      pcw <= next_pcw;
      ea <= next_ea;
      ret <= next_ret;
      tpc <= next_tpc;
      lo <= next_lo;
      mval <= next_mval;
      sp <= next_sp;
      dq <= next_dq;
      cq <= next_cq;
      mem <= next_mem;
      done <= next_done;
      busy <= next_busy;
      unsupported <= next_unsup;
      pc_out <= next_pc_out;
      y_out <= next_y_out;
      y_we <= next_y_we;
    end
  end

  // Stack pointer tracks the running value; valid with done
  assign sp_out = sp;

endmodule

// *** bjd_branch_jump_chk.sv ***
`timescale 1ns/10ps
module bjd_branch_jump_chk #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [15:0] pc_in,
  input wire bjd_pkg::bjd_core_s core,
  input wire logic [7:0] mem_rdata,
  input wire bjd_pkg::bjd_mem_s mem,
  input wire logic done,
  input wire logic busy,
  input wire logic unsupported,
  input wire logic [15:0] pc_out,
  input wire logic [7:0] sp_out,
  input wire logic [7:0] y_out,
  input wire logic y_we
);
  // ========================================
  // Accepted request
  logic go;
  assign go = start && !busy && !done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ========================================
  // Timing and results
  chk_flag_untaken: assert property (
    go && opcode == 8'hD0 && !core.c |=> !done ##1
    (done && pc_out == $past(pc_in, 2) + 16'h0001))
    else $error("carry branch not taken wrong");
  chk_zero_taken: assert property (
    go && opcode == 8'hF0 && core.z |-> ##4 done)
    else $error("zero branch taken cycle count wrong");
  chk_always_cycles: assert property (
    go && opcode == 8'h2F |=> !done [*3] ##1 done)
    else $error("always branch cycle count wrong");
  chk_bit_one: assert property (
    go && opcode == 8'h02 && core.a[0] |-> ##6 done)
    else $error("bit one branch cycle count wrong");
  chk_bit_zero: assert property (
    go && opcode == 8'hF2 && !core.a[7] |-> ##6 done)
    else $error("bit zero branch cycle count wrong");
  chk_push_order: assert property (
    (mem.wr && mem.addr[15:8] == 8'h01) ##1 mem.wr
    |-> (mem.addr[15:8] == 8'h01 &&
    mem.addr[7:0] == $past(mem.addr[7:0]) - 8'h01))
    else $error("second push not one below first");
  chk_call_stack: assert property (
    go && opcode == 8'h3B |-> ##8
    (done && sp_out == $past(core.sp, 8) - 8'h02))
    else $error("call stack pointer or timing wrong");
  chk_upage_high: assert property (
    go && opcode == 8'h4F |-> ##6 (done && pc_out[15:8] == 8'hFF))
    else $error("upper page call wrong");
  chk_table_call: assert property (
    go && opcode[3:0] == 4'hA |-> ##8
    (done && sp_out == $past(core.sp, 8) - 8'h02))
    else $error("table call wrong");
  chk_dec_y: assert property (
    go && opcode == 8'h7B && core.y != 8'h01 |-> ##6
    (done && y_we && y_out == $past(core.y, 6) - 8'h01))
    else $error("decrement Y wrong");
  chk_jump_abs: assert property (
    go && opcode == 8'h1B |=> !done ##1 !done ##1 done)
    else $error("absolute jump cycle count wrong");
endmodule

bind bjd_branch_jump bjd_branch_jump_chk #(.CNT_W(CNT_W)) bjd_branch_jump_chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .opcode(opcode),
  .pc_in(pc_in), .core(core), .mem_rdata(mem_rdata), .mem(mem),
  .done(done), .busy(busy), .unsupported(unsupported), .pc_out(pc_out),
  .sp_out(sp_out), .y_out(y_out), .y_we(y_we)
);

// *** bjd_consts.svh ***
`ifndef BJD_CONSTS_SVH
`define BJD_CONSTS_SVH

// ========================================
// Opcodes with fixed encodings
`define BJD_OP_CARRY_ZERO 8'h50
`define BJD_OP_CARRY_ONE 8'hD0
`define BJD_OP_ZERO_SET 8'hF0
`define BJD_OP_ZERO_CLEAR 8'h70
`define BJD_OP_NEG_SET 8'h90
`define BJD_OP_NEG_CLEAR 8'h10
`define BJD_OP_OVF_CLEAR 8'h30
`define BJD_OP_OVF_SET 8'hB0
`define BJD_OP_REL_ALWAYS 8'h2F
`define BJD_OP_CALL_ABS 8'h3B
`define BJD_OP_CALL_IDP 8'h5F
`define BJD_OP_CMP_DP 8'hFD
`define BJD_OP_CMP_DPX 8'h8D
`define BJD_OP_DEC_DP 8'hAC
`define BJD_OP_DEC_Y 8'h7B
`define BJD_OP_JMP_ABS 8'h1B
`define BJD_OP_JMP_IABS 8'h1F
`define BJD_OP_JMP_IDP 8'h3F
`define BJD_OP_UPAGE_CALL 8'h4F

// ========================================
// Low nibbles of the bit and table forms
`define BJD_LN_BIT_A 4'h2
`define BJD_LN_BIT_DP 4'h3
`define BJD_LN_TABLE 4'hA

// ========================================
// Cycle counts, opcode fetch included
`define BJD_CYC_FLAG_NT 4'h2
`define BJD_CYC_FLAG_T 4'h4
`define BJD_CYC_ALWAYS 4'h4
`define BJD_CYC_BITA_NT 4'h4
`define BJD_CYC_BITA_T 4'h6
`define BJD_CYC_BITDP_NT 4'h5
`define BJD_CYC_BITDP_T 4'h7
`define BJD_CYC_CMPX_NT 4'h6
`define BJD_CYC_CMPX_T 4'h8
`define BJD_CYC_JMP_ABS 4'h3
`define BJD_CYC_JMP_IABS 4'h5
`define BJD_CYC_JMP_IDP 4'h4
`define BJD_CYC_CALL 4'h8
`define BJD_CYC_UPAGE 4'h6
`define BJD_CYC_ONE 4'h1

// ========================================
// Address map
`define BJD_STACK_PAGE 8'h01
`define BJD_UPAGE_HIGH 8'hFF
`define BJD_VEC_BASE 16'hFFC0

`endif

// *** bjd_decode.sv ***
`timescale 1ns/10ps
`include "bjd_consts.svh"

module bjd_decode (
  input wire logic [7:0] opcode,
  input wire bjd_pkg::bjd_core_s core,
  output bjd_pkg::bjd_dec_s dec
);

  always_comb begin
    dec = '0;
    dec.cls = bjd_pkg::BJD_C_NONE;
    dec.bit_num = opcode[7:5];
    dec.bit_pol = ~opcode[4];
    dec.vec = opcode[7:4];
    dec.cyc_nt = `BJD_CYC_ONE;
    dec.cyc_t = `BJD_CYC_ONE;
    if (opcode[3:0] == `BJD_LN_BIT_A) begin
      dec.cls = bjd_pkg::BJD_C_BIT_A;
      dec.cyc_nt = `BJD_CYC_BITA_NT;
      dec.cyc_t = `BJD_CYC_BITA_T;
    end else if (opcode[3:0] == `BJD_LN_BIT_DP) begin
      dec.cls = bjd_pkg::BJD_C_BIT_DP;
      dec.cyc_nt = `BJD_CYC_BITDP_NT;
      dec.cyc_t = `BJD_CYC_BITDP_T;
    end else if (opcode[3:0] == `BJD_LN_TABLE) begin
      dec.cls = bjd_pkg::BJD_C_TABLE;
      dec.cyc_nt = `BJD_CYC_CALL;
      dec.cyc_t = `BJD_CYC_CALL;
    end else begin
      dec.cyc_nt = `BJD_CYC_FLAG_NT;
      dec.cyc_t = `BJD_CYC_FLAG_T;
      case (opcode)
        `BJD_OP_CARRY_ZERO: dec.flag_take = ~core.c;
        `BJD_OP_CARRY_ONE: dec.flag_take = core.c;
        `BJD_OP_ZERO_SET: dec.flag_take = core.z;
        `BJD_OP_ZERO_CLEAR: dec.flag_take = ~core.z;
        `BJD_OP_NEG_SET: dec.flag_take = core.n;
        `BJD_OP_NEG_CLEAR: dec.flag_take = ~core.n;
        `BJD_OP_OVF_CLEAR: dec.flag_take = ~core.v;
        `BJD_OP_OVF_SET: dec.flag_take = core.v;
        `BJD_OP_REL_ALWAYS: begin
          dec.flag_take = 1'b1;
          dec.cyc_nt = `BJD_CYC_ALWAYS;
          dec.cyc_t = `BJD_CYC_ALWAYS;
        end
        default: dec.flag_take = 1'b0;
      endcase
      case (opcode)
        `BJD_OP_CARRY_ZERO, `BJD_OP_CARRY_ONE, `BJD_OP_ZERO_SET,
        `BJD_OP_ZERO_CLEAR, `BJD_OP_NEG_SET, `BJD_OP_NEG_CLEAR,
        `BJD_OP_OVF_CLEAR, `BJD_OP_OVF_SET, `BJD_OP_REL_ALWAYS: begin
          dec.cls = bjd_pkg::BJD_C_FLAG;
        end
        `BJD_OP_CMP_DP: begin
          dec.cls = bjd_pkg::BJD_C_CMP_DP;
          dec.cyc_nt = `BJD_CYC_BITDP_NT;
          dec.cyc_t = `BJD_CYC_BITDP_T;
        end
        `BJD_OP_CMP_DPX: begin
          dec.cls = bjd_pkg::BJD_C_CMP_DPX;
          dec.cyc_nt = `BJD_CYC_CMPX_NT;
          dec.cyc_t = `BJD_CYC_CMPX_T;
        end
        `BJD_OP_DEC_DP: begin
          dec.cls = bjd_pkg::BJD_C_DEC_DP;
          dec.cyc_nt = `BJD_CYC_BITDP_NT;
          dec.cyc_t = `BJD_CYC_BITDP_T;
        end
        `BJD_OP_DEC_Y: begin
          dec.cls = bjd_pkg::BJD_C_DEC_Y;
          dec.cyc_nt = `BJD_CYC_BITA_NT;
          dec.cyc_t = `BJD_CYC_BITA_T;
        end
        `BJD_OP_JMP_ABS: begin
          dec.cls = bjd_pkg::BJD_C_JMP_ABS;
          dec.cyc_nt = `BJD_CYC_JMP_ABS;
          dec.cyc_t = `BJD_CYC_JMP_ABS;
        end
        `BJD_OP_JMP_IABS: begin
          dec.cls = bjd_pkg::BJD_C_JMP_IABS;
          dec.cyc_nt = `BJD_CYC_JMP_IABS;
          dec.cyc_t = `BJD_CYC_JMP_IABS;
        end
        `BJD_OP_JMP_IDP: begin
          dec.cls = bjd_pkg::BJD_C_JMP_IDP;
          dec.cyc_nt = `BJD_CYC_JMP_IDP;
          dec.cyc_t = `BJD_CYC_JMP_IDP;
        end
        `BJD_OP_CALL_ABS, `BJD_OP_CALL_IDP: begin
          dec.cls = (opcode == `BJD_OP_CALL_ABS) ? bjd_pkg::BJD_C_CALL_ABS
                                                 : bjd_pkg::BJD_C_CALL_IDP;
          dec.cyc_nt = `BJD_CYC_CALL;
          dec.cyc_t = `BJD_CYC_CALL;
        end
        `BJD_OP_UPAGE_CALL: begin
          dec.cls = bjd_pkg::BJD_C_UPAGE;
          dec.cyc_nt = `BJD_CYC_UPAGE;
          dec.cyc_t = `BJD_CYC_UPAGE;
        end
        default: begin
          dec.cls = bjd_pkg::BJD_C_NONE;
          dec.cyc_nt = `BJD_CYC_ONE;
          dec.cyc_t = `BJD_CYC_ONE;
        end
      endcase
    end
  end

endmodule

// *** bjd_mem_model.sv ***
`timescale 1ns/10ps
module bjd_mem_model (
  input wire logic ref_clk,
  input wire bjd_pkg::bjd_mem_s mem,
  output logic [7:0] mem_rdata
);
  // ========================================
  // Program and stack storage
  logic [7:0] ram [0:65535];
  logic [7:0] churn = 8'h3C;

  // Idle bus shows a moving pattern so stale data is never mistaken for a read
  always_comb begin
    mem_rdata = mem.rd ? ram[mem.addr] : churn;
  end

  always @(posedge ref_clk) begin
    churn <= churn + 8'h5B;
    if (mem.wr) begin
      ram[mem.addr] <= mem.wdata;
    end
  end
endmodule

// *** bjd_pkg.sv ***
package bjd_pkg;

  // ========================================
  // Instruction classes
  typedef enum logic [3:0] {
    BJD_C_NONE,
    BJD_C_FLAG,
    BJD_C_BIT_A,
    BJD_C_BIT_DP,
    BJD_C_CMP_DP,
    BJD_C_CMP_DPX,
    BJD_C_DEC_DP,
    BJD_C_DEC_Y,
    BJD_C_JMP_ABS,
    BJD_C_JMP_IABS,
    BJD_C_JMP_IDP,
    BJD_C_CALL_ABS,
    BJD_C_CALL_IDP,
    BJD_C_UPAGE,
    BJD_C_TABLE
  } bjd_class_e;

  // ========================================
  // Carriers
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
    logic n;
    logic v;
    logic g;
    logic z;
    logic c;
  } bjd_core_s;

  typedef struct packed {
    bjd_class_e cls;
    logic [3:0] cyc_nt;
    logic [3:0] cyc_t;
    logic flag_take;
    logic [2:0] bit_num;
    logic bit_pol;
    logic [3:0] vec;
  } bjd_dec_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bjd_mem_s;

endpackage

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  // ========================================
  // Stimulus and hookup
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  bjd_pkg::bjd_core_s core = '0;
  logic [7:0] mem_rdata;
  bjd_pkg::bjd_mem_s mem;
  logic done, busy, unsupported, y_we;
  logic [15:0] pc_out;
  logic [7:0] sp_out, y_out;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] seed = 16'h003E;
  logic [7:0] ops [28] = '{8'h50, 8'hD0, 8'hF0, 8'h70, 8'h90, 8'h10, 8'h30,
    8'hB0, 8'h2F, 8'h3B, 8'h5F, 8'hFD, 8'h8D, 8'hAC, 8'h7B, 8'h1B, 8'h1F,
    8'h3F, 8'h4F, 8'h02, 8'h12, 8'hF2, 8'hF3, 8'h63, 8'h0A, 8'hFA, 8'h00,
    8'hFF};

  always #25 ref_clk = ~ref_clk;

  bjd_branch_jump bjd_branch_jump_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .start(start), .opcode(opcode), .pc_in(pc_in), .core(core),
    .mem_rdata(mem_rdata), .mem(mem), .done(done), .busy(busy),
    .unsupported(unsupported), .pc_out(pc_out), .sp_out(sp_out),
    .y_out(y_out), .y_we(y_we));
  bjd_mem_model bjd_mem_model_i (.ref_clk(ref_clk), .mem(mem),
    .mem_rdata(mem_rdata));

  // ========================================
  // Helpers
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic [7:0] rd(input logic [15:0] a);
    return bjd_mem_model_i.ram[a];
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Expected cycles, next pc, return address, operand address and result
  task automatic predict(input logic [7:0] op, input logic [15:0] pc,
      input bjd_pkg::bjd_core_s c, output logic [7:0] cyc,
      output logic [15:0] npc, output logic [15:0] ret,
      output logic [15:0] ea, output logic [7:0] m);
    logic [15:0] p, vt;
    logic [7:0] fl, rel, nt, tk;
    logic take;
    fl = {c.z, c.c, c.v, c.n, !c.z, !c.c, !c.v, !c.n};
    ea = {7'h00, c.g, rd(pc)};
    p = {rd(pc + 16'h1), rd(pc)};
    vt = 16'hFFC0 + {11'h000, op[7:4], 1'b0};
    rel = rd(pc);
    npc = pc + 16'h1;
    ret = 16'h0000;
    m = 8'h00;
    take = 1'b0;
    {nt, tk} = 16'h0808;
    casez (op)
      8'b???10000: begin
        take = fl[op[7:5]];
        {nt, tk} = 16'h0204;
      end
      8'h2F: begin
        take = 1'b1;
        {nt, tk} = 16'h0404;
      end
      8'b????0010: begin
        take = c.a[op[7:5]] ^ op[4];
        {nt, tk} = 16'h0406;
      end
      8'b????0011: begin
        m = rd(ea);
        take = m[op[7:5]] ^ op[4];
        {nt, tk} = 16'h0507;
      end
      8'hFD, 8'h8D: begin
        ea[7:0] = ea[7:0] + (op[4] ? 8'h00 : c.x);
        take = c.a != rd(ea);
        {nt, tk} = op[4] ? 16'h0507 : 16'h0608;
      end
      8'hAC: begin
        m = rd(ea) - 8'h01;
        take = m != 8'h00;
        {nt, tk} = 16'h0507;
      end
      8'h7B: begin
        m = c.y - 8'h01;
        take = m != 8'h00;
        {nt, tk} = 16'h0406;
      end
      8'h1B: {npc, nt} = {p, 8'h03};
      8'h1F: {npc, nt} = {rd(p + 16'h1), rd(p), 8'h05};
      8'h3F: {npc, nt} = {rd(ea + 16'h1), rd(ea), 8'h04};
      8'h3B: {npc, ret} = {p, pc + 16'h2};
      8'h5F: {npc, ret} = {rd(ea + 16'h1), rd(ea), pc + 16'h1};
      8'h4F: {npc, ret, nt} = {8'hFF, rd(pc), pc + 16'h1, 8'h06};
      8'b????1010: {npc, ret} = {rd(vt + 16'h1), rd(vt), pc};
      default: {npc, nt} = {pc, 8'h01};
    endcase
    if (op[3:0] == 4'h3 || op == 8'hFD || op == 8'h8D || op == 8'hAC) begin
      rel = rd(pc + 16'h1);
      npc = pc + 16'h2;
    end
    if (take) begin
      npc = npc + {{8{rel[7]}}, rel};
    end
    cyc = take ? tk : nt;
  endtask

  // ========================================
  // One instruction: random state, directed opcodes first
  task automatic run_one(input int i);
    logic [7:0] op, cyc, m, k;
    logic [15:0] r, pc, npc, ret, ea;
    logic [47:0] r48;
    bjd_pkg::bjd_core_s c;
    r = rnd();
    op = (i < 112) ? ops[i % 28] : ops[r % 16'h001C];
    if (i >= 112 && op[3:0] inside {4'h2, 4'h3, 4'hA}) op[7:4] = r[15:12];
    r48 = {rnd(), rnd(), rnd()};
    c = r48[43:0];
    if (i % 5 == 2) c.y = 8'h01;
    // Keeps the pointer out of the stack page the call writes first
    if (op == 8'h5F) c.g = 1'b0;
    r = rnd();
    pc = {3'h1, r[12:0]};
    r = rnd();
    bjd_mem_model_i.ram[pc] = (i % 5 == 0) ? 8'h80 : r[7:0];
    bjd_mem_model_i.ram[pc + 16'h1] = (i % 5 == 1) ? 8'h7F : r[15:8];
    if (op == 8'h5F) bjd_mem_model_i.ram[pc][7] = 1'b0;
    predict(op, pc, c, cyc, npc, ret, ea, m);
    if (i % 5 == 3) begin
      c.a = rd(ea);
      predict(op, pc, c, cyc, npc, ret, ea, m);
    end
    @(posedge ref_clk);
    start <= 1'b1;
    opcode <= op;
    pc_in <= pc;
    core <= c;
    @(posedge ref_clk);
    start <= 1'b0;
    opcode <= ~op;
    pc_in <= ~pc;
    core <= ~c;
    k = 8'h01;
    #1;
    check({15'h0, busy}, {15'h0, cyc != 8'h01}, "busy");
    while (done !== 1'b1 && k < 8'h14) begin
      @(posedge ref_clk);
      #1;
      k = k + 8'h01;
    end
    check({8'h00, k}, {8'h00, cyc}, "cycles");
    check(pc_out, npc, "next pc");
    check({15'h0, unsupported}, {15'h0, cyc == 8'h01}, "foreign");
    check({15'h0, y_we}, {15'h0, op == 8'h7B}, "y write");
    if (op == 8'h7B) check({8'h00, y_out}, {8'h00, m}, "y");
    if (op == 8'hAC) check({8'h00, rd(ea)}, {8'h00, m}, "dec");
    if (ret != 16'h0000) begin
      check({8'h00, sp_out}, {8'h00, c.sp - 8'h02}, "sp");
      r = {rd({8'h01, c.sp}), rd({8'h01, c.sp - 8'h01})};
      check(r, ret, "pushed return");
    end
    $display("Test %0d opcode %h cycles %0d", i, op, k);
  endtask

  // ========================================
  // Verdict
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Worst case is about 2200 cycles; the limit leaves wide margin
  initial begin
    #300000;
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    for (int a = 0; a < 65536; a++) begin
      bjd_mem_model_i.ram[a] = 8'(rnd());
    end
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 240; i++) begin
      run_one(i);
    end
    summarize();
  end
endmodule
